// File: pkg/sslc_pkg.sv
// Package with register map, reset values and timing constants for the serial link config block.
package sslc_pkg;
   // Register word addresses as the host sees them.
   localparam logic [15:0] SSLC_ADDR_STATION = 16'h0300;
   localparam logic [15:0] SSLC_ADDR_BIT_RATE = 16'h0302;
   localparam logic [15:0] SSLC_ADDR_PROTOCOL = 16'h0304;
   localparam logic [15:0] SSLC_ADDR_TIMEOUT = 16'h0308;
   localparam logic [15:0] SSLC_ADDR_RESP_DELAY = 16'h030E;
   // Values after reset.
   localparam logic [15:0] SSLC_RST_STATION = 16'h007F;
   localparam logic [15:0] SSLC_RST_BIT_RATE = 16'h0033;
   localparam logic [15:0] SSLC_RST_PROTOCOL = 16'h0066;
   localparam logic [15:0] SSLC_RST_TIMEOUT = 16'h0000;
   localparam logic [15:0] SSLC_RST_RESP_DELAY = 16'h0000;
   // Legal ranges.
   localparam logic [7:0] SSLC_STATION_MIN = 8'h01;
   localparam logic [7:0] SSLC_STATION_MAX = 8'h7F;
   localparam logic [7:0] SSLC_BROADCAST_ADDR = 8'hFF;
   localparam logic [3:0] SSLC_RATE_CODE_MAX = 4'h5;
   localparam logic [3:0] SSLC_PROTO_CODE_MAX = 4'h8;
   localparam logic [3:0] SSLC_PROTO_RTU_FIRST = 4'h6;
   localparam logic [15:0] SSLC_TIMEOUT_MAX = 16'h0014;
   localparam logic [15:0] SSLC_RESP_DELAY_MAX = 16'h03E8;
   // Field positions.
   localparam int SSLC_RS232_LSB = 0;
   localparam int SSLC_RS485_LSB = 4;
   // Timing.
   localparam int SSLC_CLOCK_HZ = 250000000;
   localparam int SSLC_TICK_MS = 1;
   localparam int SSLC_MS_CYCLES = SSLC_CLOCK_HZ / 1000 * SSLC_TICK_MS;
   localparam int SSLC_MS_PER_SEC = 1000;
   // Framing codes.
   typedef enum logic [2:0] {
      SSLC_DATA7_NONE2, SSLC_DATA7_EVEN1, SSLC_DATA7_ODD1,
      SSLC_DATA8_NONE2, SSLC_DATA8_EVEN1, SSLC_DATA8_ODD1
   } sslc_frame_e;
endpackage : sslc_pkg

// File: design/sslc_tick.sv
// Millisecond tick divider producing a one-cycle enable pulse.
`timescale 1ns/1ps
module sslc_tick
   import sslc_pkg::*;
#(
   parameter int CYCLES = SSLC_MS_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Tick out
   output logic tick
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt = cnt_r + 32'h00000001;
      if (cnt_r >= 32'(CYCLES - 1)) begin
         cnt_nxt = 32'h00000000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 32'h00000000;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule : sslc_tick

// File: design/sslc_link_config.sv
// Serial slave link configuration, address match, idle timeout and reply delay.
//
// Behaviour
// - Station number 16-bit, 0x01..0x7F, reset 0x7F.
// - Low digit is axis number 0..F.
// - Second digit group 0..7, upper zero.
// - Host address 0xFF accepted and answered whenever no reply is pending.
// - Station number write of 0xFF refused.
// - Bit rate digits per port 0..5, reset 0x0033.
// - Rate code selects 4800 to 115200 bps.
// - Protocol digit per port selects ASCII/RTU framing.
// - Nonzero idle timeout seconds flags communication fault.
// - Reply waits programmable 1 ms steps, 0..1000.
`timescale 1ns/1ps
module sslc_link_config
   import sslc_pkg::*;
#(
   parameter int MS_CYCLES = SSLC_MS_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Parameter access port, word addressed
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [15:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   output logic cfg_ack,
   output logic cfg_err,
   // Received frame address and reply request
   input wire logic frame_valid,
   input wire logic [7:0] frame_addr,
   output logic reply_go,
   output logic reply_pending,
   // Communication activity and fault
   input wire logic comm_activity,
   input wire logic fault_clear,
   output logic comm_fault,
   // Decoded port settings
   output logic [16:0] rs232_baud,
   output logic [16:0] rs485_baud,
   output logic [2:0] rs232_frame,
   output logic [2:0] rs485_frame,
   output logic rs232_rtu,
   output logic rs485_rtu
);
   //////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [16:0] rate_of(input logic [3:0] code);
      case (code)
         4'h0: rate_of = 17'd4800;
         4'h1: rate_of = 17'd9600;
         4'h2: rate_of = 17'd19200;
         4'h3: rate_of = 17'd38400;
         4'h4: rate_of = 17'd57600;
         default: rate_of = 17'd115200;
      endcase
   endfunction : rate_of

   function automatic logic [2:0] frame_of(input logic [3:0] code);
      // RTU codes reuse the three 8-bit framings.
      if (code >= SSLC_PROTO_RTU_FIRST) begin
         frame_of = 3'(code - SSLC_PROTO_RTU_FIRST) + 3'(SSLC_DATA8_NONE2);
      end else begin
         frame_of = code[2:0];
      end
   endfunction : frame_of

   //////////////////////////////////////////////////////////////////////////////////////////
   logic tick_ms;
   sslc_tick #(.CYCLES(MS_CYCLES)) u_tick (
      .clock(clock),
      .rst_b(rst_b),
      .tick(tick_ms)
   );

   //////////////////////////////////////////////////////////////////////////////////////////
   logic [15:0] station_r, station_nxt;
   logic [15:0] rate_r, rate_nxt;
   logic [15:0] proto_r, proto_nxt;
   logic [15:0] timeout_r, timeout_nxt;
   logic [15:0] delay_r, delay_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic ack_r, ack_nxt;
   logic err_r, err_nxt;

   always_comb begin
      station_nxt = station_r;
      rate_nxt = rate_r;
      proto_nxt = proto_r;
      timeout_nxt = timeout_r;
      delay_nxt = delay_r;
      rdata_nxt = 16'h0000;
      ack_nxt = cfg_wr | cfg_rd;
      err_nxt = 1'b0;
      if (cfg_wr) begin
         // Out-of-range writes leave the old value and report an error.
         case (cfg_addr)
            SSLC_ADDR_STATION: begin
               if (cfg_wdata[15:8] == 8'h00 && cfg_wdata[7:0] != SSLC_BROADCAST_ADDR
                   && cfg_wdata[7:0] >= SSLC_STATION_MIN
                   && cfg_wdata[7:0] <= SSLC_STATION_MAX) begin
                  station_nxt = cfg_wdata;
               end else begin
                  err_nxt = 1'b1;
               end
            end
            SSLC_ADDR_BIT_RATE: begin
               if (cfg_wdata[15:8] == 8'h00 && cfg_wdata[7:4] <= SSLC_RATE_CODE_MAX
                   && cfg_wdata[3:0] <= SSLC_RATE_CODE_MAX) begin
                  rate_nxt = cfg_wdata;
               end else begin
                  err_nxt = 1'b1;
               end
            end
            SSLC_ADDR_PROTOCOL: begin
               if (cfg_wdata[15:8] == 8'h00 && cfg_wdata[7:4] <= SSLC_PROTO_CODE_MAX
                   && cfg_wdata[3:0] <= SSLC_PROTO_CODE_MAX) begin
                  proto_nxt = cfg_wdata;
               end else begin
                  err_nxt = 1'b1;
               end
            end
            SSLC_ADDR_TIMEOUT: begin
               if (cfg_wdata <= SSLC_TIMEOUT_MAX) begin
                  timeout_nxt = cfg_wdata;
               end else begin
                  err_nxt = 1'b1;
               end
            end
            SSLC_ADDR_RESP_DELAY: begin
               if (cfg_wdata <= SSLC_RESP_DELAY_MAX) begin
                  delay_nxt = cfg_wdata;
               end else begin
                  err_nxt = 1'b1;
               end
            end
            default: err_nxt = 1'b1;
         endcase
      end else if (cfg_rd) begin
         case (cfg_addr)
            SSLC_ADDR_STATION: rdata_nxt = station_r;
            SSLC_ADDR_BIT_RATE: rdata_nxt = rate_r;
            SSLC_ADDR_PROTOCOL: rdata_nxt = proto_r;
            SSLC_ADDR_TIMEOUT: rdata_nxt = timeout_r;
            SSLC_ADDR_RESP_DELAY: rdata_nxt = delay_r;
            default: err_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         station_r <= SSLC_RST_STATION;
         rate_r <= SSLC_RST_BIT_RATE;
         proto_r <= SSLC_RST_PROTOCOL;
         timeout_r <= SSLC_RST_TIMEOUT;
         delay_r <= SSLC_RST_RESP_DELAY;
         rdata_r <= 16'h0000;
         ack_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         station_r <= station_nxt;
         rate_r <= rate_nxt;
         proto_r <= proto_nxt;
         timeout_r <= timeout_nxt;
         delay_r <= delay_nxt;
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
         err_r <= err_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Reply scheduling: a matched frame loads the delay, the reply fires after it expires.
   typedef enum logic [1:0] {SSLC_IDLE, SSLC_WAIT, SSLC_FIRE} sslc_reply_e;
   sslc_reply_e rstate_r, rstate_nxt;
   logic [15:0] dcnt_r, dcnt_nxt;
   logic go_r, go_nxt;
   logic pend_r, pend_nxt;
   logic match;

   assign match = frame_valid && (frame_addr == SSLC_BROADCAST_ADDR
                  || frame_addr == station_r[7:0]);

   always_comb begin
      rstate_nxt = rstate_r;
      dcnt_nxt = dcnt_r;
      go_nxt = 1'b0;
      case (rstate_r)
         SSLC_IDLE: begin
            // The reply cycle still counts as pending, so a frame landing in it is refused.
            if (match && !go_r) begin
               dcnt_nxt = delay_r;
               rstate_nxt = SSLC_WAIT;
            end
         end
         SSLC_WAIT: begin
            if (dcnt_r == 16'h0000) begin
               rstate_nxt = SSLC_FIRE;
            end else if (tick_ms) begin
               dcnt_nxt = dcnt_r - 16'h0001;
            end
         end
         SSLC_FIRE: begin
            go_nxt = 1'b1;
            rstate_nxt = SSLC_IDLE;
         end
         default: rstate_nxt = SSLC_IDLE;
      endcase
      pend_nxt = (rstate_nxt != SSLC_IDLE) || go_nxt;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstate_r <= SSLC_IDLE;
         dcnt_r <= 16'h0000;
         go_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         rstate_r <= rstate_nxt;
         dcnt_r <= dcnt_nxt;
         go_r <= go_nxt;
         pend_r <= pend_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Idle watchdog counts milliseconds since the last activity.
   logic [15:0] idle_ms_r, idle_ms_nxt;
   logic fault_r, fault_nxt;
   logic [31:0] limit_ms;

   assign limit_ms = 32'(timeout_r) * 32'(SSLC_MS_PER_SEC);

   always_comb begin
      idle_ms_nxt = idle_ms_r;
      fault_nxt = fault_r;
      if (comm_activity || timeout_r == 16'h0000) begin
         idle_ms_nxt = 16'h0000;
      end else if (tick_ms && idle_ms_r != 16'hFFFF) begin
         idle_ms_nxt = idle_ms_r + 16'h0001;
      end
      if (fault_clear) begin
         fault_nxt = 1'b0;
      end
      // Set wins over a clear in the same cycle.
      if (timeout_r != 16'h0000 && 32'(idle_ms_r) >= limit_ms) begin
         fault_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         idle_ms_r <= 16'h0000;
         fault_r <= 1'b0;
      end else begin
         idle_ms_r <= idle_ms_nxt;
         fault_r <= fault_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   logic [16:0] b232_r, b485_r, b232_nxt, b485_nxt;
   logic [2:0] f232_r, f485_r, f232_nxt, f485_nxt;
   logic rtu232_r, rtu485_r, rtu232_nxt, rtu485_nxt;

   always_comb begin
      b232_nxt = rate_of(rate_r[SSLC_RS232_LSB +: 4]);
      b485_nxt = rate_of(rate_r[SSLC_RS485_LSB +: 4]);
      f232_nxt = frame_of(proto_r[SSLC_RS232_LSB +: 4]);
      f485_nxt = frame_of(proto_r[SSLC_RS485_LSB +: 4]);
      rtu232_nxt = proto_r[SSLC_RS232_LSB +: 4] >= SSLC_PROTO_RTU_FIRST;
      rtu485_nxt = proto_r[SSLC_RS485_LSB +: 4] >= SSLC_PROTO_RTU_FIRST;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         b232_r <= 17'd38400;
         b485_r <= 17'd38400;
         f232_r <= 3'(SSLC_DATA8_NONE2);
         f485_r <= 3'(SSLC_DATA8_NONE2);
         rtu232_r <= 1'b1;
         rtu485_r <= 1'b1;
      end else begin
         b232_r <= b232_nxt;
         b485_r <= b485_nxt;
         f232_r <= f232_nxt;
         f485_r <= f485_nxt;
         rtu232_r <= rtu232_nxt;
         rtu485_r <= rtu485_nxt;
      end
   end

   assign cfg_rdata = rdata_r;
   assign cfg_ack = ack_r;
   assign cfg_err = err_r;
   assign reply_go = go_r;
   assign reply_pending = pend_r;
   assign comm_fault = fault_r;
   assign rs232_baud = b232_r;
   assign rs485_baud = b485_r;
   assign rs232_frame = f232_r;
   assign rs485_frame = f485_r;
   assign rs232_rtu = rtu232_r;
   assign rs485_rtu = rtu485_r;
endmodule : sslc_link_config

// File: verification/sslc_link_config_props.sv
// Checker for the port behaviour of the serial link configuration block.
`timescale 1ns/1ps
module sslc_link_config_props
   import sslc_pkg::*;
#(
   parameter int MS_CYCLES = SSLC_MS_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Parameter access port
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [15:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   input wire logic [15:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire logic cfg_err,
   // Frames and replies
   input wire logic frame_valid,
   input wire logic [7:0] frame_addr,
   input wire logic reply_go,
   input wire logic reply_pending,
   // Activity and fault
   input wire logic comm_activity,
   input wire logic fault_clear,
   input wire logic comm_fault,
   // Decoded settings
   input wire logic [16:0] rs232_baud,
   input wire logic [16:0] rs485_baud,
   input wire logic [2:0] rs232_frame,
   input wire logic [2:0] rs485_frame,
   input wire logic rs232_rtu,
   input wire logic rs485_rtu
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence s_host_frame;
      frame_valid && frame_addr == 8'hFF && !reply_pending;
   endsequence
   sequence s_reply_done;
      reply_pending ##1 !reply_pending;
   endsequence
   ack_follows_a: assert property ((cfg_wr || cfg_rd) |=> cfg_ack) else $error("no ack");
   ack_cause_a: assert property (cfg_ack |-> $past(cfg_wr || cfg_rd)) else $error("stray ack");
   err_with_ack_a: assert property (cfg_err |-> cfg_ack) else $error("lone err");
   rdata_idle_a: assert property (!cfg_ack |-> cfg_rdata == 16'h0000) else $error("rdata");
   host_take_a: assert property (s_host_frame |=> reply_pending) else $error("host frame");
   reply_end_a: assert property (reply_go |-> s_reply_done) else $error("reply end");
   fault_hold_a: assert property (comm_fault && !fault_clear |=> comm_fault) else $error("fault");
   rate_legal_a: assert property (rs232_baud inside {4800, 9600, 19200, 38400, 57600, 115200})
      else $error("rate");
   rtu_frame_a: assert property (rs485_rtu |-> rs485_frame inside {3, 4, 5}) else $error("rtu");
endmodule : sslc_link_config_props
bind sslc_link_config sslc_link_config_props #(.MS_CYCLES(MS_CYCLES)) u_props (
   .clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
   .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
   .frame_valid(frame_valid), .frame_addr(frame_addr), .reply_go(reply_go),
   .reply_pending(reply_pending), .comm_activity(comm_activity), .fault_clear(fault_clear),
   .comm_fault(comm_fault), .rs232_baud(rs232_baud), .rs485_baud(rs485_baud),
   .rs232_frame(rs232_frame), .rs485_frame(rs485_frame), .rs232_rtu(rs232_rtu),
   .rs485_rtu(rs485_rtu));

// File: verification/sslc_host_model.sv
// Host controller model that sends frame addresses and times the reply.
`timescale 1ns/1ps
module sslc_host_model (
   // Clock
   input wire logic clock,
   // Reply request
   input wire logic reply_go,
   // Frame to the drive
   output logic frame_valid,
   output logic [7:0] frame_addr
);
   initial begin
      frame_valid = 1'b0;
      frame_addr = 8'h00;
   end
   // Returns the cycle count to the reply, or 0 when none comes within lim cycles.
   task automatic send_frame(input logic [7:0] addr, input int lim, output int n);
      @(negedge clock);
      frame_valid = 1'b1;
      frame_addr = addr;
      @(negedge clock);
      frame_valid = 1'b0;
      // A stale address must not look like a fresh one.
      frame_addr = ~addr;
      n = 0;
      for (int i = 1; i <= lim && n == 0; i++) begin
         @(posedge clock);
         #1;
         if (reply_go === 1'b1) n = i;
      end
      // The reply cycle still counts as pending, so the next frame waits one edge.
      @(posedge clock);
   endtask : send_frame
endmodule : sslc_host_model

// File: verification/serial_slave_link_config_tb_top.sv
// Self-checking testbench for the serial link configuration block.
`timescale 1ns/1ps
module serial_slave_link_config_tb_top;
   import sslc_pkg::*;
   // A short millisecond keeps the idle timeout run small.
   localparam int MS = 4;
   logic clock, rst_b, cfg_wr, cfg_rd, comm_activity, fault_clear, er;
   logic [15:0] cfg_addr, cfg_wdata, cfg_rdata, rd;
   logic cfg_ack, cfg_err, frame_valid, reply_go, reply_pending, comm_fault;
   logic [7:0] frame_addr;
   logic [16:0] rs232_baud, rs485_baud;
   logic [2:0] rs232_frame, rs485_frame;
   logic rs232_rtu, rs485_rtu;
   int n_errors = 0;
   int comparisons = 0;
   int n;
   sslc_link_config #(.MS_CYCLES(MS)) dut (.clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .cfg_err(cfg_err), .frame_valid(frame_valid), .frame_addr(frame_addr),
      .reply_go(reply_go), .reply_pending(reply_pending), .comm_activity(comm_activity),
      .fault_clear(fault_clear), .comm_fault(comm_fault), .rs232_baud(rs232_baud),
      .rs485_baud(rs485_baud), .rs232_frame(rs232_frame), .rs485_frame(rs485_frame),
      .rs232_rtu(rs232_rtu), .rs485_rtu(rs485_rtu));
   sslc_host_model host (.clock(clock), .reply_go(reply_go), .frame_valid(frame_valid),
      .frame_addr(frame_addr));
   task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic cfg(input logic we, input logic [15:0] a, input logic [15:0] d);
      @(negedge clock);
      cfg_wr = we;
      cfg_rd = !we;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge clock);
      chk("ack", 17'h00001, 17'(cfg_ack));
      er = cfg_err;
      rd = cfg_rdata;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_wdata = ~d;
   endtask : cfg
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
      cfg(1'b1, a, d);
      chk("err", 17'(e), 17'(er));
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      cfg(1'b0, a, 16'h0000);
      chk("rdata", 17'(exp), 17'(rd));
   endtask : rdc
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdc(SSLC_ADDR_STATION, 16'h007F);
      rdc(SSLC_ADDR_BIT_RATE, 16'h0033);
      rdc(SSLC_ADDR_PROTOCOL, 16'h0066);
      rdc(SSLC_ADDR_TIMEOUT, 16'h0000);
      rdc(SSLC_ADDR_RESP_DELAY, 16'h0000);
      chk("rs485_baud", 17'h09600, rs485_baud);
      $display("test reset done");
   endtask : t_reset
   task automatic t_station;
      logic [15:0] bad[4] = '{16'h00FF, 16'h0000, 16'h0080, 16'h017A};
      wr(SSLC_ADDR_STATION, 16'h007A, 1'b0);
      foreach (bad[i]) wr(SSLC_ADDR_STATION, bad[i], 1'b1);
      rdc(SSLC_ADDR_STATION, 16'h007A);
      wr(16'h0306, 16'h0000, 1'b1);
      $display("test station done");
   endtask : t_station
   task automatic t_rates;
      int bps[6] = '{4800, 9600, 19200, 38400, 57600, 115200};
      for (int c = 0; c < 6; c++) begin
         wr(SSLC_ADDR_BIT_RATE, {8'h00, 4'(5 - c), 4'(c)}, 1'b0);
         repeat (2) @(negedge clock);
         chk("rs232_baud", 17'(bps[c]), rs232_baud);
         chk("rs485_baud", 17'(bps[5 - c]), rs485_baud);
      end
      wr(SSLC_ADDR_BIT_RATE, 16'h0006, 1'b1);
      wr(SSLC_ADDR_BIT_RATE, 16'h0100, 1'b1);
      $display("test rates done");
   endtask : t_rates
   task automatic t_proto;
      logic [3:0] x;
      for (int p = 0; p < 9; p++) begin
         wr(SSLC_ADDR_PROTOCOL, {8'h00, 4'(8 - p), 4'(p)}, 1'b0);
         repeat (2) @(negedge clock);
         x = {p > 5, 3'(p > 5 ? p - 3 : p)};
         chk("rs232", 17'(x), 17'({rs232_rtu, rs232_frame}));
         x = {p < 3, 3'(p < 3 ? 5 - p : 8 - p)};
         chk("rs485", 17'(x), 17'({rs485_rtu, rs485_frame}));
      end
      wr(SSLC_ADDR_PROTOCOL, 16'h0009, 1'b1);
      $display("test protocol done");
   endtask : t_proto
   task automatic t_reply;
      wr(SSLC_ADDR_STATION, 16'h0025, 1'b0);
      host.send_frame(8'h25, 20, n);
      chk("own reply", 17'h00002, 17'(n));
      host.send_frame(8'h26, 40, n);
      chk("foreign", 17'h00000, 17'(n));
      host.send_frame(8'hFF, 20, n);
      chk("host reply", 17'h00002, 17'(n));
      wr(SSLC_ADDR_RESP_DELAY, 16'h0002, 1'b0);
      host.send_frame(8'h25, 40, n);
      chk("delay", 17'h00001, 17'(n >= MS + 2 && n <= 2 * MS + 4));
      wr(SSLC_ADDR_RESP_DELAY, 16'h03E9, 1'b1);
      $display("test reply done");
   endtask : t_reply
   task automatic t_timeout;
      wr(SSLC_ADDR_TIMEOUT, 16'h0015, 1'b1);
      wr(SSLC_ADDR_TIMEOUT, 16'h0001, 1'b0);
      @(negedge clock);
      comm_activity = 1'b0;
      n = 0;
      for (int i = 1; i <= 5000 && n == 0; i++) begin
         @(posedge clock);
         #1;
         if (comm_fault === 1'b1) n = i;
      end
      chk("fault time", 17'h00001, 17'(n >= 1000 * MS - MS - 2 && n <= 1000 * MS + 4));
      @(negedge clock);
      comm_activity = 1'b1;
      @(negedge clock);
      chk("fault sticky", 17'h00001, 17'(comm_fault));
      fault_clear = 1'b1;
      @(negedge clock);
      fault_clear = 1'b0;
      repeat (2) @(negedge clock);
      chk("fault clear", 17'h00000, 17'(comm_fault));
      $display("test timeout done");
   endtask : t_timeout
   task automatic finish_test;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      rst_b = 1'b0;
      {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, fault_clear} = '0;
      comm_activity = 1'b1;
      repeat (20) @(negedge clock);
      rst_b = 1'b1;
      t_reset;
      t_station;
      t_rates;
      t_proto;
      t_reply;
      t_timeout;
      finish_test;
   end
   initial begin
      #80000;
      n_errors++;
      $display("BAD watchdog expected 0 seen 1");
      finish_test;
   end
endmodule : serial_slave_link_config_tb_top
